// ===== design/rvq_pkg.sv
// Shared constants, register map and carrier types of the reactive/apparent datapath
package rvq_pkg;

  // Sample timing: 125 us period (8 kHz) on a 200 MHz core clock
  localparam int unsigned CLK_PERIOD_PS    = 5000;
  localparam int unsigned SAMPLE_PERIOD_NS = 125000;
  localparam int unsigned SAMPLE_CYCLES    =
    (SAMPLE_PERIOD_NS * 1000) / CLK_PERIOD_PS;

  // Datapath widths
  localparam int unsigned DW  = 24;   // waveform, rms, gain, nominal_voltage_value width
  localparam int unsigned PW  = 27;   // instantaneous reactive power width
  localparam int unsigned EW  = 32;   // var-hour register width
  localparam int unsigned TW  = 48;   // reactive threshold width
  localparam int unsigned NCH = 6;    // three total plus three fundamental

  // Scaling of products into power words
  localparam int unsigned REACT_SHIFT = 21;
  localparam int unsigned APP_SHIFT   = 23;
  localparam logic signed [28:0] UNITY_GAIN = 29'h0080_0000;

  // Register indices on the register port
  localparam logic [4:0] REG_THR_LO   = 5'h00;
  localparam logic [4:0] REG_THR_HI   = 5'h01;
  localparam logic [4:0] REG_ACCUMULATION_MODE_REG  = 5'h02;
  localparam logic [4:0] REG_LINE_CYCLE_MODE_REG = 5'h03;
  localparam logic [4:0] REG_HALF_CYCLE_COUNT  = 5'h04;
  localparam logic [4:0] REG_COMPENSATION_MODE_REG = 5'h05;
  localparam logic [4:0] REG_NOMINAL_VOLTAGE_VALUE     = 5'h06;
  localparam logic [4:0] REG_GAIN_A   = 5'h07;
  localparam logic [4:0] REG_VA_A     = 5'h0A;
  localparam logic [4:0] REG_VARHR_A  = 5'h0D;
  localparam logic [4:0] REG_STATUS   = 5'h13;

  // Field positions
  localparam int unsigned CONNECTION_SELECT_LSB  = 4;
  localparam int unsigned REACTIVE_OUTPUT_SIGN_MODE_LSB  = 2;
  localparam int unsigned LINE_CYCLE_REACTIVE_ENABLE_BIT    = 1;
  localparam int unsigned ZERO_CROSS_PHASE_SELECT_LSB   = 3;
  localparam int unsigned RESET_ON_READ_ENABLE_BIT = 6;
  localparam int unsigned VNOMEN_LSB  = 11;
  localparam int unsigned DONE_BIT    = 5;

  // Reset values
  localparam logic [7:0]  ACCUMULATION_MODE_REG_RST  = 8'h00;
  localparam logic [7:0]  LINE_CYCLE_MODE_REG_RST = 8'h38;
  localparam logic [15:0] HALF_CYCLE_COUNT_RST  = 16'hFFFF;
  localparam logic [15:0] COMPENSATION_MODE_REG_RST = 16'h0000;

  // Wiring connection codes
  typedef enum logic [1:0] {
    CON_FOUR_WIRE = 2'b00,
    CON_B_ZERO    = 2'b01,
    CON_B_NEG_AC  = 2'b10,
    CON_B_NEG_A   = 2'b11
  } rvq_connection_select_e;

  // Per-phase measurement inputs
  typedef struct packed {
    logic signed [DW-1:0] v;     // instantaneous voltage
    logic signed [DW-1:0] iq;    // phase-shifted current
    logic signed [PW-1:0] fq;    // instantaneous fundamental reactive power
    logic        [DW-1:0] vrms;  // voltage rms
    logic        [DW-1:0] irms;  // current rms
  } rvq_phase_s;

  // Register port request
  typedef struct packed {
    logic          wr;
    logic          rd;
    logic [4:0]    addr;
    logic [EW-1:0] wdata;
  } rvq_reg_req_s;

endpackage

// ===== design/rvq_var_energy.sv
// Two-stage reactive energy accumulator for one channel
`timescale 1ns/1ps
module rvq_var_energy
  import rvq_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_b_i,
  // Sample and control
  input  wire logic                 tick_i,
  input  wire logic signed [PW-1:0] power_i,
  input  wire logic [TW-1:0]        thr_i,
  input  wire logic                 load_i,
  input  wire logic                 clr_i,
  // Results
  output logic [EW-1:0]             live_o,
  output logic [EW-1:0]             held_o,
  output logic                      pulse_o
);

  logic signed [TW:0] stage1_r;
  logic signed [TW:0] thr_s;
  logic signed [TW:0] sum;
  logic signed [TW:0] stage1_nxt;
  logic               pos_hit;
  logic               neg_hit;
  logic [EW-1:0]      step;
  logic [EW-1:0]      live_nxt;

  // First stage: add power each tick, emit at most one pulse per tick when the sum reaches plus or minus threshold
  assign thr_s   = {1'b0, thr_i};
  assign sum     = stage1_r + (TW+1)'(power_i);
  assign pos_hit = tick_i && (sum >= thr_s);
  assign neg_hit = tick_i && !pos_hit && (sum <= -thr_s);
  assign stage1_nxt = !tick_i ? stage1_r :
                      pos_hit ? sum - thr_s :
                      neg_hit ? sum + thr_s : sum;

  // Second stage: signed pulse count, wraps naturally at 32 bits
  assign step     = pos_hit ? 32'h0000_0001 :
                    neg_hit ? 32'hFFFF_FFFF : 32'h0000_0000;
  assign live_nxt = ((load_i || clr_i) ? 32'h0000_0000 : live_o) + step;

  // A pulse in the loading cycle counts in the finished period and also starts the new one
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stage1_r <= '0;
      live_o   <= '0;
      held_o   <= '0;
      pulse_o  <= 1'b0;
    end else begin
      stage1_r <= stage1_nxt;
      live_o   <= load_i ? step : live_nxt;
      held_o   <= load_i ? live_o + step : held_o;
      pulse_o  <= pos_hit || neg_hit;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_sub_threshold;
    pos_hit |=> (stage1_r == $past(sum) - $past(thr_s));
  endproperty
  a_sub_threshold: assert property (p_sub_threshold)
    else $error("threshold not subtracted after pulse");

  property p_sub_wrap;
    (live_o == 32'h7FFF_FFFF) && pos_hit && !load_i && !clr_i
      |=> (live_o == 32'h8000_0000);
  endproperty
  a_sub_wrap: assert property (p_sub_wrap)
    else $error("var-hour did not wrap to full-scale negative");

  property p_sub_hold;
    !tick_i |=> (stage1_r == $past(stage1_r)) && !pulse_o;
  endproperty
  a_sub_hold: assert property (p_sub_hold)
    else $error("first stage moved outside a sample tick");

  c_sub_wrap: cover property (live_o == 32'h7FFF_FFFF ##1
                              live_o == 32'h8000_0000);

endmodule

// ===== design/rvq_reactive_apparent.sv
// Reactive energy accumulation and apparent power datapath, three phases
`timescale 1ns/1ps

module rvq_reactive_apparent #(
  parameter int unsigned SAMPLE_CYCLES = rvq_pkg::SAMPLE_CYCLES
) (
  // Clock and reset
  input  wire logic                     CORE_CLK_I,
  input  wire logic                     RST_B_I,
  // Measurements and zero crossings
  input  wire rvq_pkg::rvq_phase_s [2:0] PHASE_I,
  input  wire logic [2:0]               ZX_I,
  // Register port
  input  wire rvq_pkg::rvq_reg_req_s    REG_REQ_I,
  output logic [31:0]                   REG_RDATA_O,
  output logic                          REG_RVALID_O,
  // Status toward the rest of the device
  output logic [5:0]                    VAR_PULSE_O,
  output logic [1:0]                    FREQ_SIGN_MODE_O,
  output logic                          SAMPLE_TICK_O,
  output logic                          LINE_DONE_O
);
  import rvq_pkg::*;

  logic [31:0]    tick_cnt_r;
  logic           tick_r;
  logic [23:0]    thr_lo_r;
  logic [23:0]    thr_hi_r;
  logic [7:0]     accumulation_mode_reg_r;
  logic [7:0]     line_cycle_mode_reg_r;
  logic [15:0]    half_cycle_count_r;
  logic [15:0]    compensation_mode_reg_r;
  logic [23:0]    nominal_voltage_value_r;
  logic [23:0]    gain_r  [3];
  logic [23:0]    va_r    [3];
  logic [15:0]    zx_cnt_r;
  logic           done_r;
  logic [31:0]    rdata_nxt;
  logic [EW-1:0]  live    [NCH];
  logic [EW-1:0]  held    [NCH];
  logic [NCH-1:0] pulse;
  logic [NCH-1:0] rd_clr;
  logic signed [PW-1:0] q_pow [NCH];
  logic [23:0]    va_nxt  [3];

  // Multiply helpers shared by all three phases
  function automatic logic signed [PW-1:0] react_pow(
    input logic signed [DW:0]   v,
    input logic signed [DW-1:0] i);
    logic signed [2*DW:0] prod;
    prod = v * (DW+1)'(i);
    return prod[REACT_SHIFT+PW-1:REACT_SHIFT];
  endfunction

  function automatic logic [23:0] app_pow(
    input logic [DW-1:0] vr,
    input logic [DW-1:0] ir,
    input logic [DW-1:0] gain);
    logic [2*DW-1:0]    raw;
    logic signed [27:0] g28;
    logic signed [28:0] mult;
    logic signed [54:0] scaled;
    raw    = vr * ir;
    g28    = 28'(signed'(gain));
    mult   = UNITY_GAIN + 29'(g28);
    scaled = $signed({30'h0, raw[2*DW-1:APP_SHIFT]}) * 55'(mult);
    return scaled[APP_SHIFT+23:APP_SHIFT];
  endfunction

  // Decoded control fields
  wire [1:0]  connection_select   = accumulation_mode_reg_r[CONNECTION_SELECT_LSB +: 2];
  wire        line_cycle_reactive_enable     = line_cycle_mode_reg_r[LINE_CYCLE_REACTIVE_ENABLE_BIT];
  wire        reset_on_read_enable  = line_cycle_mode_reg_r[RESET_ON_READ_ENABLE_BIT];
  wire [2:0]  zero_cross_phase_select    = line_cycle_mode_reg_r[ZERO_CROSS_PHASE_SELECT_LSB +: 3];
  wire [2:0]  nominal_voltage_value_en  = compensation_mode_reg_r[VNOMEN_LSB +: 3];
  wire [47:0] thr      = {thr_hi_r, thr_lo_r};
  wire        wr       = REG_REQ_I.wr;
  wire [4:0]  addr     = REG_REQ_I.addr;
  wire [31:0] wdata    = REG_REQ_I.wdata;

  // Phase B voltage by wiring connection
  wire signed [DW:0] va_ext = (DW+1)'(PHASE_I[0].v);
  wire signed [DW:0] vc_ext = (DW+1)'(PHASE_I[2].v);
  wire signed [DW:0] vb_eff =
    (connection_select == CON_B_NEG_AC) ? -va_ext - vc_ext :
    (connection_select == CON_B_NEG_A)  ? -va_ext :
                               (DW+1)'(PHASE_I[1].v);
  wire b_zero = (connection_select == CON_B_ZERO);

  // Reactive power per channel, signed whatever the output mode
  assign q_pow[0] = react_pow(va_ext, PHASE_I[0].iq);
  assign q_pow[1] = b_zero ? '0 : react_pow(vb_eff, PHASE_I[1].iq);
  assign q_pow[2] = react_pow(vc_ext, PHASE_I[2].iq);
  assign q_pow[3] = PHASE_I[0].fq;
  assign q_pow[4] = b_zero ? '0 : PHASE_I[1].fq;
  assign q_pow[5] = PHASE_I[2].fq;

  // Line-cycle counting over the selected zero crossings
  wire zx_hit  = |(ZX_I & zero_cross_phase_select);
  wire load_w  = line_cycle_reactive_enable && zx_hit &&
                 (zx_cnt_r + 16'h0001 >= half_cycle_count_r);
  wire done_clr = wr && (addr == REG_STATUS) && wdata[DONE_BIT];

  // Sample tick: free-running divider of the core clock
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else begin
      tick_r     <= (tick_cnt_r == SAMPLE_CYCLES - 1);
      tick_cnt_r <= (tick_cnt_r == SAMPLE_CYCLES - 1) ? '0
                                                      : tick_cnt_r + 1;
    end
  end

  // Energy channels: 0..2 total, 3..5 fundamental
  for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
    assign rd_clr[ch] = REG_REQ_I.rd && reset_on_read_enable && !line_cycle_reactive_enable &&
                        (addr == REG_VARHR_A + 5'(ch));
    rvq_var_energy u_energy (
      .clk_i   (CORE_CLK_I),
      .rst_b_i (RST_B_I),
      .tick_i  (tick_r),
      .power_i (q_pow[ch]),
      .thr_i   (thr),
      .load_i  (load_w),
      .clr_i   (rd_clr[ch]),
      .live_o  (live[ch]),
      .held_o  (held[ch]),
      .pulse_o (pulse[ch])
    );
  end

  // Apparent power: rms product or nominal voltage substitute
  for (genvar p = 0; p < 3; p++) begin : g_va
    assign va_nxt[p] = app_pow(nominal_voltage_value_en[p] ? nominal_voltage_value_r : PHASE_I[p].vrms,
                               PHASE_I[p].irms, gain_r[p]);
  end

  // Configuration registers written by software
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      thr_lo_r   <= '0;
      thr_hi_r   <= '0;
      accumulation_mode_reg_r  <= ACCUMULATION_MODE_REG_RST;
      line_cycle_mode_reg_r <= LINE_CYCLE_MODE_REG_RST;
      half_cycle_count_r  <= HALF_CYCLE_COUNT_RST;
      compensation_mode_reg_r <= COMPENSATION_MODE_REG_RST;
      nominal_voltage_value_r     <= '0;
      gain_r     <= '{default: '0};
    end else if (wr) begin
      unique case (addr)
        REG_THR_LO:   thr_lo_r   <= wdata[23:0];
        REG_THR_HI:   thr_hi_r   <= wdata[23:0];
        REG_ACCUMULATION_MODE_REG:  accumulation_mode_reg_r  <= wdata[7:0];
        REG_LINE_CYCLE_MODE_REG: line_cycle_mode_reg_r <= wdata[7:0];
        REG_HALF_CYCLE_COUNT:  half_cycle_count_r  <= wdata[15:0];
        REG_COMPENSATION_MODE_REG: compensation_mode_reg_r <= wdata[15:0];
        REG_NOMINAL_VOLTAGE_VALUE:     nominal_voltage_value_r     <= wdata[23:0];
        REG_GAIN_A:   gain_r[0]  <= wdata[23:0];
        REG_GAIN_A + 5'h01: gain_r[1] <= wdata[23:0];
        REG_GAIN_A + 5'h02: gain_r[2] <= wdata[23:0];
        default: ;
      endcase
    end
  end

  // Results, line-cycle counter and done flag; set beats clear
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      va_r     <= '{default: '0};
      zx_cnt_r <= '0;
      done_r   <= 1'b0;
    end else begin
      if (tick_r) va_r <= va_nxt;
      zx_cnt_r <= !line_cycle_reactive_enable ? '0 : load_w ? '0 :
                  zx_hit ? zx_cnt_r + 16'h0001 : zx_cnt_r;
      done_r   <= load_w || (done_r && !done_clr);
    end
  end

  // Read mux; var-hour shows live sum or the line-cycle snapshot
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (addr)
      REG_THR_LO:   rdata_nxt = {8'h00, thr_lo_r};
      REG_THR_HI:   rdata_nxt = {8'h00, thr_hi_r};
      REG_ACCUMULATION_MODE_REG:  rdata_nxt = {24'h00_0000, accumulation_mode_reg_r};
      REG_LINE_CYCLE_MODE_REG: rdata_nxt = {24'h00_0000, line_cycle_mode_reg_r};
      REG_HALF_CYCLE_COUNT:  rdata_nxt = {16'h0000, half_cycle_count_r};
      REG_COMPENSATION_MODE_REG: rdata_nxt = {16'h0000, compensation_mode_reg_r};
      REG_NOMINAL_VOLTAGE_VALUE:     rdata_nxt = {8'h00, nominal_voltage_value_r};
      REG_STATUS:   rdata_nxt = 32'(done_r) << DONE_BIT;
      default: begin
        for (int k = 0; k < 3; k++) begin
          if (addr == REG_GAIN_A + 5'(k)) rdata_nxt = {8'h00, gain_r[k]};
          if (addr == REG_VA_A + 5'(k))   rdata_nxt = {8'h00, va_r[k]};
        end
        for (int k = 0; k < NCH; k++) begin
          if (addr == REG_VARHR_A + 5'(k)) begin
            rdata_nxt = line_cycle_reactive_enable ? held[k] : live[k];
          end
        end
      end
    endcase
  end

  // Output flops
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      REG_RDATA_O      <= '0;
      REG_RVALID_O     <= 1'b0;
      VAR_PULSE_O      <= '0;
      FREQ_SIGN_MODE_O <= '0;
      SAMPLE_TICK_O    <= 1'b0;
      LINE_DONE_O      <= 1'b0;
    end else begin
      REG_RDATA_O      <= REG_REQ_I.rd ? rdata_nxt : REG_RDATA_O;
      REG_RVALID_O     <= REG_REQ_I.rd;
      VAR_PULSE_O      <= pulse;
      FREQ_SIGN_MODE_O <= accumulation_mode_reg_r[REACTIVE_OUTPUT_SIGN_MODE_LSB +: 2];
      SAMPLE_TICK_O    <= tick_r;
      LINE_DONE_O      <= done_r;
    end
  end

  // Checks
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);

  logic [31:0] gap_r;
  logic        seen_r;
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      gap_r  <= '0;
      seen_r <= 1'b0;
    end else begin
      gap_r  <= tick_r ? '0 : gap_r + 1;
      seen_r <= seen_r || tick_r;
    end
  end
  // Reference products at full width; a narrower product loses its top bits
  wire [24:0] base_b = 25'((48'(nominal_voltage_value_r) * 48'(PHASE_I[1].irms))
                           >> APP_SHIFT);
  wire [24:0] base_c = 25'((48'(PHASE_I[2].vrms) * 48'(PHASE_I[2].irms))
                           >> APP_SHIFT);

  property p_tick_gap;
    tick_r && seen_r |-> (gap_r == SAMPLE_CYCLES - 1);
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("sample tick spacing wrong");

  property p_b_zero;
    b_zero |-> (q_pow[1] == '0) && (q_pow[4] == '0);
  endproperty
  a_b_zero: assert property (p_b_zero)
    else $error("phase B not forced to zero");

  property p_read_live;
    REG_REQ_I.rd && (addr == REG_VARHR_A) && !line_cycle_reactive_enable
      |=> REG_RVALID_O && (REG_RDATA_O == $past(live[0]));
  endproperty
  a_read_live: assert property (p_read_live)
    else $error("var-hour read does not return live sum");

  property p_line_hold;
    line_cycle_reactive_enable && !load_w |=> $stable(held[0]) && $stable(held[4]);
  endproperty
  a_line_hold: assert property (p_line_hold)
    else $error("line snapshot moved before count elapsed");

  property p_line_load;
    load_w |=> done_r && (zx_cnt_r == '0) ##1 LINE_DONE_O;
  endproperty
  a_line_load: assert property (p_line_load)
    else $error("line-cycle completion not handled");

  property p_zx_mask;
    line_cycle_reactive_enable && !zx_hit |=> $stable(zx_cnt_r);
  endproperty
  a_zx_mask: assert property (p_zx_mask)
    else $error("unselected crossing counted");

  property p_nominal_voltage_value_sel;
    tick_r && nominal_voltage_value_en[1] && (gain_r[1] == '0)
      |=> va_r[1] == $past(base_b[23:0]);
  endproperty
  a_nominal_voltage_value_sel: assert property (p_nominal_voltage_value_sel)
    else $error("nominal voltage not substituted");

  property p_gain_half;
    tick_r && !nominal_voltage_value_en[2] && (gain_r[2] == 24'hC0_0000)
      |=> va_r[2] == $past(base_c[24:1]);
  endproperty
  a_gain_half: assert property (p_gain_half)
    else $error("negative half gain not applied");

  property p_gain_unity;
    tick_r && !nominal_voltage_value_en[2] && (gain_r[2] == '0)
      |=> va_r[2] == $past(base_c[23:0]);
  endproperty
  a_gain_unity: assert property (p_gain_unity)
    else $error("unity gain changed apparent power");

  c_line_load: cover property (line_cycle_reactive_enable && load_w);
  c_b_zero:    cover property (b_zero && tick_r && |pulse);
  c_nominal_voltage_value:      cover property (tick_r && |nominal_voltage_value_en);
  c_rd_clr:    cover property (|rd_clr);

endmodule

// ===== testbench/tb_rvq_reactive_apparent.sv
// Self-checking bench for the reactive energy and apparent power datapath
`timescale 1ns/1ps
module tb_rvq_reactive_apparent;
  import rvq_pkg::*;

  // Short sample period keeps the run brief
  localparam int unsigned SC = 20;
  // Nominal voltage word that stands for full-scale rms voltage
  localparam int unsigned NOMINAL_VOLTAGE_VALUE_FS = 32'h003F_F6A6;

  logic             clk = 1'b0;
  logic             rst_b = 1'b0;
  rvq_phase_s [2:0] phase = '0;
  logic [2:0]       zx = 3'h0;
  rvq_reg_req_s     req = '0;
  logic [31:0]      rdata;
  logic             rvalid;
  logic [5:0]       pulse;
  logic [1:0]       sign_mode;
  logic             tick;
  logic             done;
  logic [31:0]      exp_q[$];
  logic [31:0]      msk_q[$];
  int               fails = 0;
  int               compares = 0;
  int               gap = -1;
  logic [31:0]      seed = 32'h6e09_13d0;

  // 200 MHz core clock
  always #2.5 clk = ~clk;

  rvq_reactive_apparent #(.SAMPLE_CYCLES(SC)) i_rvq_reactive_apparent (
    .CORE_CLK_I       (clk),
    .RST_B_I          (rst_b),
    .PHASE_I          (phase),
    .ZX_I             (zx),
    .REG_REQ_I        (req),
    .REG_RDATA_O      (rdata),
    .REG_RVALID_O     (rvalid),
    .VAR_PULSE_O      (pulse),
    .FREQ_SIGN_MODE_O (sign_mode),
    .SAMPLE_TICK_O    (tick),
    .LINE_DONE_O      (done)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  // Apparent power: rms product, then gain as one plus g over 2^23
  function automatic logic [31:0] app(input logic [23:0] vr,
                                      input logic [23:0] ir,
                                      input logic [23:0] g);
    longint p;
    p = (longint'(vr) * longint'(ir)) >>> 23;
    p = (p * (longint'(UNITY_GAIN) + longint'(signed'(g)))) >>> 23;
    return {8'h00, p[23:0]};
  endfunction

  task automatic close_out();
    if (fails == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    compares++;
    if (got !== e) begin
      fails++;
      $display("Error at %0t: level %h expected %h", $time, got, e);
    end
  endtask

  // Strobe held one edge, then one idle edge so no double assignment
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge clk);
    req.wr <= 1'b0;
    @(posedge clk);
  endtask

  // A zero mask marks a read whose answer is discarded
  task automatic rd(input logic [4:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hFFFF_FFFF);
    exp_q.push_back(e);
    msk_q.push_back(m);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    req.rd <= 1'b0;
    @(posedge clk);
  endtask

  // Align to a sample tick, then move a fixed offset into the period
  task automatic sync(input int off);
    int k;
    k = 0;
    @(posedge clk);
    while (tick !== 1'b1 && k < 100) begin
      @(posedge clk);
      k++;
    end
    repeat (off) @(posedge clk);
  endtask

  // Read answers compared against the oldest note; tick spacing measured
  always @(negedge clk) begin
    logic [31:0] e;
    logic [31:0] m;
    if (rvalid === 1'b1) begin
      compares++;
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      if (((rdata ^ e) & m) !== 32'h0) begin
        fails++;
        $display("Error at %0t: read %h expected %h", $time, rdata, e);
      end
    end
    if (tick === 1'b1) begin
      if (gap >= 0) begin
        compares++;
        if (gap !== SC) begin
          fails++;
          $display("Error at %0t: tick spacing %0d", $time, gap);
        end
      end
      gap = 1;
    end else if (gap >= 0) begin
      gap++;
    end
  end

  // Main sequence
  initial begin
    logic [23:0] vr[3];
    logic [23:0] ir[3];
    logic [23:0] g[3];
    logic [23:0] iqb[4];
    logic [23:0] vn;
    g = '{24'h40_0000, 24'h00_0000, 24'hC0_0000};
    iqb = '{24'h40_0000, 24'h40_0000, 24'hE0_0000, 24'hC0_0000};
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(REG_ACCUMULATION_MODE_REG, 32'h0000_0000);
    rd(REG_LINE_CYCLE_MODE_REG, 32'h0000_0038);
    rd(REG_HALF_CYCLE_COUNT, 32'h0000_FFFF);
    rd(REG_COMPENSATION_MODE_REG, 32'h0000_0000);
    rd(5'h1F, 32'h0000_0000);
    // Random rms inputs; phase B takes the nominal voltage instead
    for (int p = 0; p < 3; p++) begin
      seed = xs(seed);
      vr[p] = seed[23:0];
      seed = xs(seed);
      ir[p] = seed[23:0];
      phase[p].vrms <= vr[p];
      phase[p].irms <= ir[p];
      wr(REG_GAIN_A + 5'(p), {8'hF0, g[p]});
    end
    seed = xs(seed);
    // Nominal word for a random fraction of full-scale voltage
    vn = 24'((64'(seed[15:0]) * NOMINAL_VOLTAGE_VALUE_FS) >> 16);
    wr(REG_NOMINAL_VOLTAGE_VALUE, {8'hA5, vn});
    wr(REG_COMPENSATION_MODE_REG, 32'h0000_1000);
    rd(REG_NOMINAL_VOLTAGE_VALUE, {8'h00, vn});
    rd(REG_COMPENSATION_MODE_REG, 32'h0000_1000);
    sync(0);
    sync(3);
    for (int p = 0; p < 3; p++) begin
      rd(REG_GAIN_A + 5'(p), {8'h00, g[p]});
      rd(REG_VA_A + 5'(p), app(p == 1 ? vn : vr[p], ir[p], g[p]));
    end
    // Clearing the phase C gain leaves the bare rms product
    wr(REG_GAIN_A + 5'h02, 32'h0000_0000);
    sync(3);
    rd(REG_VA_A + 5'h02, app(vr[2], ir[2], 24'h00_0000));
    // Power equal to the threshold gives one pulse per tick
    wr(REG_THR_LO, 32'h0080_0000);
    wr(REG_THR_HI, 32'h0000_0000);
    for (int p = 0; p < 3; p++) begin
      phase[p].v <= 24'h40_0000;
      phase[p].iq <= 24'h40_0000;
      phase[p].fq <= 27'h080_0000;
    end
    wr(REG_LINE_CYCLE_MODE_REG, 32'h0000_0078);
    for (int c = 0; c < 4; c++) begin
      wr(REG_ACCUMULATION_MODE_REG, {26'h0, 2'(c), 2'(c), 2'h0});
      phase[1].iq <= iqb[c];
      sync(4);
      chk({30'h0, sign_mode}, 32'(c));
      for (int k = 0; k < 4; k++) begin
        rd(k == 3 ? 5'h11 : REG_VARHR_A + 5'(k), 32'h0, 32'h0);
      end
      sync(0);
      // Pulse outputs stand in the cycle after the delayed tick
      sync(1);
      chk({26'h0, pulse}, c == 1 ? 32'h0000_002D : 32'h0000_003F);
      sync(4);
      rd(REG_VARHR_A, 32'h0000_0003);
      rd(REG_VARHR_A + 5'h01, c == 1 ? 32'h0 : 32'h3);
      rd(REG_VARHR_A + 5'h02, 32'h0000_0003);
      rd(5'h11, c == 1 ? 32'h0 : 32'h3);
    end
    // Line mode counting phase A crossings only, reset-on-read off
    wr(REG_ACCUMULATION_MODE_REG, 32'h0000_0000);
    phase[1].iq <= 24'h40_0000;
    wr(REG_HALF_CYCLE_COUNT, 32'h0000_0002);
    wr(REG_LINE_CYCLE_MODE_REG, 32'h0000_000A);
    for (int n = 0; n < 8; n++) begin
      sync(6);
      zx <= {1'b0, n == 6, n == 0 || n == 3 || n == 5 || n == 7};
      @(posedge clk);
      zx <= 3'h0;
    end
    sync(3);
    chk({31'h0, done}, 32'h0000_0001);
    rd(REG_STATUS, 32'h0000_0020, 32'h0000_0020);
    rd(REG_VARHR_A, 32'h0000_0004);
    rd(5'h12, 32'h0000_0004);
    sync(0);
    sync(3);
    rd(REG_VARHR_A + 5'h01, 32'h0000_0004);
    wr(REG_STATUS, 32'h0000_0020);
    rd(REG_STATUS, 32'h0000_0000, 32'h0000_0020);
    chk({31'h0, done}, 32'h0000_0000);
    repeat (4) @(posedge clk);
    close_out();
  end

  // Watchdog well beyond the expected run of about 650 cycles
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    close_out();
  end

endmodule
